/* shared/pmbs_pkg.sv */
// constants, types and helpers shared by the program memory block switch
package pmbs_pkg;
  localparam int ADDR_W = 16;
  localparam int WIN_MSB = 15;
  localparam int WIN_LSB = 13;
  localparam logic [2:0] WIN_TAG = 3'h0;
  localparam logic [1:0] MAP_OVERLAY = 2'h0;
  localparam logic MAP_HI_SW = 1'h1;
  localparam logic MAP_HI_COLD = 1'h0;
  localparam logic NV_PROG = 1'h0;
  localparam logic NV_UNPROG = 1'h1;
  localparam logic [31:0] OFF_MAP = 32'h0000_0000;
  localparam logic [31:0] OFF_STAT = 32'h0000_0004;
  localparam logic [31:0] OFF_IAP = 32'h0000_0008;
  // command word for the startup bit program command (value is arbitrary)
  localparam logic [31:0] IAP_KEY_PROG_SC = 32'h0000_00A5;
  localparam int PROG_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PCNT_W = 8;
  typedef enum logic [1:0] {
    RK_COLD = 2'b00,
    RK_WARM = 2'b01,
    RK_SW   = 2'b10
  } pmbs_rst_kind_t;
  typedef enum logic [1:0] {
    ST_WAIT_NV = 2'b00,
    ST_LOAD    = 2'b01,
    ST_RUN     = 2'b10
  } pmbs_state_t;
  typedef struct packed {
    logic              valid;
    logic              blk1;
    logic [ADDR_W-1:0] addr;
  } pmbs_sel_t;
  // true when the address lies in the lowest 8 KByte window
  function automatic logic in_window(input logic [ADDR_W-1:0] a);
    in_window = (a[WIN_MSB:WIN_LSB] == WIN_TAG);
  endfunction
endpackage

/* src/pmbs_win_steer.sv */
// registered block steering for one address stream
`timescale 1ns/1ps
`default_nettype none
module pmbs_win_steer (
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // request
  input  wire logic                        req_valid,
  input  wire logic [pmbs_pkg::ADDR_W-1:0] req_addr,
  input  wire logic                        want_blk1,
  // steered result
  output var  pmbs_pkg::pmbs_sel_t         sel_r
);
  wire logic hit_w;
  assign hit_w = pmbs_pkg::in_window(req_addr) & want_blk1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sel_r <= '0;
    else
    begin
      sel_r.valid <= req_valid;
      sel_r.blk1  <= hit_w;
      sel_r.addr  <= req_addr;
    end
  end
endmodule
`default_nettype wire

/* src/pmbs_nv_cell.sv */
// nonvolatile startup bit: load after reset, one-way programming
`timescale 1ns/1ps
`default_nettype none
module pmbs_nv_cell (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // array side
  input  wire logic nv_stored,
  output logic      prog_strobe_r,
  // control
  input  wire logic prog_req,
  output logic      bit_r,
  output logic      loaded_r,
  output logic      busy_r,
  output logic      refused_r
);
  logic [pmbs_pkg::PCNT_W-1:0] cnt_r;
  wire logic accept_w;
  // programming only moves unprogrammed to programmed
  assign accept_w = prog_req & loaded_r & ~busy_r & (bit_r == pmbs_pkg::NV_UNPROG);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bit_r         <= pmbs_pkg::NV_UNPROG;
      loaded_r      <= 1'b0;
      busy_r        <= 1'b0;
      cnt_r         <= '0;
      prog_strobe_r <= 1'b0;
      refused_r     <= 1'b0;
    end
    else
    begin
      prog_strobe_r <= accept_w;
      refused_r     <= prog_req & ~accept_w;
      if (!loaded_r)
      begin
        bit_r    <= nv_stored;
        loaded_r <= 1'b1;
      end
      else if (accept_w)
      begin
        busy_r <= 1'b1;
        cnt_r  <= pmbs_pkg::PCNT_W'(pmbs_pkg::PROG_CYC - 1);
      end
      else if (busy_r)
      begin
        cnt_r <= cnt_r - 1'b1;
        if (cnt_r == '0)
        begin
          busy_r <= 1'b0;
          bit_r  <= pmbs_pkg::NV_PROG;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* src/pmbs_top.sv */
// program memory block switch: map field, reset reload, fetch steering, apb
`timescale 1ns/1ps
`default_nettype none
// Function
// - map field 00 sends fetches at 0000H-1FFFH to Block 1.
// - fetches above 1FFFH always go to Block 0.
// - map 01, 10, 11 hides Block 1 from fetch; programming still reaches it.
// - with overlay active, programming still reaches low 8K of Block 0.
// - presetn and every warm reset request in ST_RUN reload the map field from the startup bit.
// - cold reset loads 00 if unprogrammed, 01 if programmed.
// - warm reset keeps upper bit, lower bit 0 unprogrammed, 1 programmed.
// - software reset loads 10 if unprogrammed, 11 if programmed.
// - stored 0 means programmed, stored 1 means unprogrammed.
// - software may write the lower map bit only in ST_RUN; startup bit untouched.
// - startup bit changes only by host or programming command.
// - programming the startup bit leaves the map until next reset.
// - startup bit may be programmed only from unprogrammed state.
module pmbs_top (
  // apb slave
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // warm resets from the reset controller
  input  wire logic                        warm_rst_req,
  input  wire pmbs_pkg::pmbs_rst_kind_t    warm_rst_kind,
  // instruction fetch
  input  wire logic                        fetch_valid,
  input  wire logic [pmbs_pkg::ADDR_W-1:0] fetch_pc,
  output var pmbs_pkg::pmbs_sel_t          fetch_sel,
  // in-application programming path
  input  wire logic                        iap_valid,
  input  wire logic                        iap_blk1,
  input  wire logic [pmbs_pkg::ADDR_W-1:0] iap_addr,
  output var pmbs_pkg::pmbs_sel_t          iap_sel,
  // startup bit array and host mode pin
  input  wire logic                        nv_stored,
  input  wire logic                        host_prog_pin,
  output logic                             nv_prog_strobe,
  output logic [1:0]                       memory_map_config
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  pmbs_pkg::pmbs_state_t    state_r;
  pmbs_pkg::pmbs_state_t    state_nxt;
  pmbs_pkg::pmbs_rst_kind_t last_kind_r;
  logic [1:0]               map_r;
  logic [1:0]               map_nxt;
  logic                     host_s1_r;
  logic                     host_s2_r;
  logic                     host_d_r;
  logic                     prdy_r;
  logic                     perr_r;
  logic [31:0]              prd_r;
  logic                     nv_bit;
  logic                     nv_loaded;
  logic                     nv_busy;
  logic                     nv_refused;
  logic                     refused_seen_r;

  ////////////////////////////////////////////////////////////////////////////
  // reload value for each kind of reset
  function automatic logic [1:0] reload_map(input pmbs_pkg::pmbs_rst_kind_t kind,
                                            input logic nv, input logic cur_hi);
    logic lo;
    lo = (nv == pmbs_pkg::NV_PROG);
    case (kind)
      pmbs_pkg::RK_WARM: reload_map = {cur_hi, lo};
      pmbs_pkg::RK_SW:   reload_map = {pmbs_pkg::MAP_HI_SW, lo};
      default:           reload_map = {pmbs_pkg::MAP_HI_COLD, lo};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire logic setup_w;
  wire logic acc_w;
  wire logic hit_map_w;
  wire logic hit_stat_w;
  wire logic hit_iap_w;
  wire logic mapped_w;
  wire logic wr_map_w;
  wire logic wr_iap_w;
  wire logic host_rise_w;
  wire logic prog_req_w;
  wire logic run_w;
  wire logic [31:0] rd_mux_w;

  assign setup_w    = psel & ~penable;
  // pready is registered, so every transfer has one wait state
  assign acc_w      = psel & penable & prdy_r;
  assign hit_map_w  = (paddr == pmbs_pkg::OFF_MAP);
  assign hit_stat_w = (paddr == pmbs_pkg::OFF_STAT);
  assign hit_iap_w  = (paddr == pmbs_pkg::OFF_IAP);
  assign mapped_w   = hit_map_w | hit_stat_w | hit_iap_w;
  assign run_w      = (state_r == pmbs_pkg::ST_RUN);
  assign wr_map_w   = acc_w & pwrite & hit_map_w & run_w;
  assign wr_iap_w   = acc_w & pwrite & hit_iap_w & (pwdata == pmbs_pkg::IAP_KEY_PROG_SC);

  // host pin passes two flops; only the second stage feeds the edge detector
  assign host_rise_w = host_s2_r & ~host_d_r;
  // no plain register write reaches the startup bit, only these commands
  assign prog_req_w  = wr_iap_w | host_rise_w;

  assign rd_mux_w = hit_map_w  ? {30'h0000_0000, map_r} :
                    hit_stat_w ? {26'h000_0000, refused_seen_r, nv_busy, last_kind_r,
                                  run_w, nv_bit} :
                    32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // map field next value
  always_comb
  begin
    state_nxt = state_r;
    map_nxt   = map_r;
    case (state_r)
      pmbs_pkg::ST_WAIT_NV:
      begin
        if (nv_loaded)
          state_nxt = pmbs_pkg::ST_LOAD;
      end
      pmbs_pkg::ST_LOAD:
      begin
        map_nxt   = reload_map(last_kind_r, nv_bit, map_r[1]);
        state_nxt = pmbs_pkg::ST_RUN;
      end
      pmbs_pkg::ST_RUN:
      begin
        // a reset takes priority over a software write in the same cycle
        if (warm_rst_req)
          map_nxt = reload_map(warm_rst_kind, nv_bit, map_r[1]);
        else if (wr_map_w)
          map_nxt = {map_r[1], pwdata[0]};
      end
      default:
      begin
        state_nxt = pmbs_pkg::ST_WAIT_NV;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r     <= pmbs_pkg::ST_WAIT_NV;
      map_r       <= pmbs_pkg::MAP_OVERLAY;
      last_kind_r <= pmbs_pkg::RK_COLD;
    end
    else
    begin
      state_r <= state_nxt;
      map_r   <= map_nxt;
      if (run_w && warm_rst_req)
        last_kind_r <= warm_rst_kind;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer and host pin synchroniser
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdy_r         <= 1'b0;
      perr_r         <= 1'b0;
      prd_r          <= 32'h0000_0000;
      host_s1_r      <= 1'b0;
      host_s2_r      <= 1'b0;
      host_d_r       <= 1'b0;
      refused_seen_r <= 1'b0;
    end
    else
    begin
      prdy_r    <= psel & penable & ~prdy_r;
      perr_r    <= psel & penable & ~prdy_r & ~mapped_w;
      prd_r     <= (psel & penable & ~prdy_r & ~pwrite) ? rd_mux_w : 32'h0000_0000;
      host_s1_r <= host_prog_pin;
      host_s2_r <= host_s1_r;
      host_d_r  <= host_s2_r;
      // sticky; a new refusal in the clearing cycle wins
      if (nv_refused)
        refused_seen_r <= 1'b1;
      else if (wr_map_w && pwdata[1])
        refused_seen_r <= 1'b0;
    end
  end

  assign prdata            = prd_r;
  assign pready            = prdy_r;
  assign pslverr           = perr_r;
  assign memory_map_config = map_r;

  ////////////////////////////////////////////////////////////////////////////
  // startup bit
  pmbs_nv_cell u_nv (
    .pclk          (pclk),
    .presetn       (presetn),
    .nv_stored     (nv_stored),
    .prog_strobe_r (nv_prog_strobe),
    .prog_req      (prog_req_w),
    .bit_r         (nv_bit),
    .loaded_r      (nv_loaded),
    .busy_r        (nv_busy),
    .refused_r     (nv_refused)
  );

  ////////////////////////////////////////////////////////////////////////////
  // fetch and programming steering
  wire logic overlay_w;
  // only 00 overlays Block 1; 01, 10, 11 keep it out of the fetch path
  assign overlay_w = (map_r == pmbs_pkg::MAP_OVERLAY);

  pmbs_win_steer u_fetch (
    .pclk      (pclk),
    .presetn   (presetn),
    .req_valid (fetch_valid),
    .req_addr  (fetch_pc),
    .want_blk1 (overlay_w),
    .sel_r     (fetch_sel)
  );

  // programming picks its block itself, whatever the map field holds
  pmbs_win_steer u_iap (
    .pclk      (pclk),
    .presetn   (presetn),
    .req_valid (iap_valid),
    .req_addr  (iap_addr),
    .want_blk1 (iap_blk1),
    .sel_r     (iap_sel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  fetch_overlay_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pmbs_pkg::in_window(fetch_pc) && map_r == pmbs_pkg::MAP_OVERLAY) |=> fetch_sel.blk1)
    else $error("low window fetch with map 00 not sent to block 1");

  fetch_high_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pmbs_pkg::in_window(fetch_pc) |=> !fetch_sel.blk1)
    else $error("fetch above 1FFFH sent to block 1");

  blk1_hidden_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (map_r != pmbs_pkg::MAP_OVERLAY) |=> !fetch_sel.blk1)
    else $error("block 1 visible to fetch while map is not 00");

  iap_blk0_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (iap_valid && !iap_blk1) |=> (iap_sel.valid && !iap_sel.blk1))
    else $error("programming could not reach block 0 low window");

  cold_load_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_r == pmbs_pkg::ST_LOAD && last_kind_r == pmbs_pkg::RK_COLD)
      |=> map_r == {pmbs_pkg::MAP_HI_COLD, ~$past(nv_bit)})
    else $error("cold reset map reload wrong");

  warm_load_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (run_w && warm_rst_req && warm_rst_kind == pmbs_pkg::RK_WARM)
      |=> (map_r[1] == $past(map_r[1]) && map_r[0] == ~$past(nv_bit)))
    else $error("warm reset map reload wrong");

  sw_load_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (run_w && warm_rst_req && warm_rst_kind == pmbs_pkg::RK_SW)
      |=> map_r == {pmbs_pkg::MAP_HI_SW, ~$past(nv_bit)})
    else $error("software reset map reload wrong");

  map_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_map_w && !warm_rst_req)
      |=> (map_r == {$past(map_r[1]), $past(pwdata[0])} && nv_bit == $past(nv_bit)))
    else $error("lower map bit write misbehaved");

  prog_keeps_map_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (run_w && $fell(nv_busy) && !$past(warm_rst_req) && !$past(wr_map_w))
      |-> $stable(map_r))
    else $error("programming the startup bit changed the map");

  prog_once_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (nv_loaded && nv_bit == pmbs_pkg::NV_PROG)
      |=> (!nv_prog_strobe && nv_bit == pmbs_pkg::NV_PROG))
    else $error("startup bit programmed from programmed state");

  iap_blk1_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (iap_valid && iap_blk1 && pmbs_pkg::in_window(iap_addr))
      |=> (iap_sel.valid && iap_sel.blk1))
    else $error("programming could not reach block 1");

  iap_overlay_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (overlay_w && iap_valid && !iap_blk1 && pmbs_pkg::in_window(iap_addr))
      |=> (iap_sel.valid && !iap_sel.blk1 && iap_sel.addr == $past(iap_addr)))
    else $error("block 0 low window lost to programming during overlay");

  cold_kind_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (run_w && warm_rst_req && warm_rst_kind == pmbs_pkg::RK_COLD)
      |=> map_r == {pmbs_pkg::MAP_HI_COLD, ~$past(nv_bit)})
    else $error("cold kind reset request map reload wrong");

  map_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (run_w && !warm_rst_req && !wr_map_w) |=> $stable(map_r))
    else $error("map field changed without reset or write");

  strobe_cause_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    nv_prog_strobe |-> $past(prog_req_w))
    else $error("startup bit strobe without a programming command");

  strobe_unprog_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    nv_prog_strobe |-> (nv_bit == pmbs_pkg::NV_UNPROG && nv_busy))
    else $error("startup bit strobe while already programmed");

  refused_sticky_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    nv_refused |=> refused_seen_r)
    else $error("refused programming not recorded");

  steer_lag_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> (fetch_sel.valid == $past(fetch_valid)
              && fetch_sel.addr == $past(fetch_pc)))
    else $error("fetch steering not one cycle behind the request");
endmodule
`default_nettype wire

/* verif/pmbs_nv_array.sv */
// behavioural startup bit array on the far side of the switch
`timescale 1ns/1ps
`default_nettype none
module pmbs_nv_array #(
  parameter int PROG_LAT = 0
) (
  // clock
  input  wire logic pclk,
  // array port
  input  wire logic nv_prog_strobe,
  output logic      nv_stored
);
  int cnt;
  // nonvolatile: no reset input, the cell keeps its state across every reset
  initial
  begin
    nv_stored = pmbs_pkg::NV_UNPROG;
    cnt = -1;
  end
  // only the programming strobe writes the cell, and only towards 0
  always @(posedge pclk)
  begin
    if (nv_prog_strobe === 1'b1)
      cnt <= PROG_LAT;
    else if (cnt > 0)
      cnt <= cnt - 1;
    else if (cnt == 0)
    begin
      nv_stored <= pmbs_pkg::NV_PROG;
      cnt <= -1;
    end
  end
endmodule
`default_nettype wire

/* verif/pmbs_tb_top.sv */
// self-checking bench for the program memory block switch
`timescale 1ns/1ps
`default_nettype none
module pmbs_tb_top;
  logic                     pclk;
  logic                     presetn;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [31:0]              paddr;
  logic [31:0]              pwdata;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic                     warm_rst_req;
  pmbs_pkg::pmbs_rst_kind_t warm_rst_kind;
  logic                     fetch_valid;
  logic [15:0]              fetch_pc;
  pmbs_pkg::pmbs_sel_t      fetch_sel;
  logic                     iap_valid;
  logic                     iap_blk1;
  logic [15:0]              iap_addr;
  pmbs_pkg::pmbs_sel_t      iap_sel;
  logic                     nv_stored;
  logic                     host_prog_pin;
  logic                     nv_prog_strobe;
  logic [1:0]               memory_map_config;
  logic [31:0]              rd;
  logic                     err;
  int                       n_errors;
  int                       num_checks;
  int                       n_strobe;

  pmbs_top dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .warm_rst_req(warm_rst_req),
    .warm_rst_kind(warm_rst_kind), .fetch_valid(fetch_valid), .fetch_pc(fetch_pc),
    .fetch_sel(fetch_sel), .iap_valid(iap_valid), .iap_blk1(iap_blk1),
    .iap_addr(iap_addr), .iap_sel(iap_sel), .nv_stored(nv_stored),
    .host_prog_pin(host_prog_pin), .nv_prog_strobe(nv_prog_strobe),
    .memory_map_config(memory_map_config)
  );

  pmbs_nv_array #(.PROG_LAT(3)) nv_u (
    .pclk(pclk), .nv_prog_strobe(nv_prog_strobe), .nv_stored(nv_stored)
  );

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk)
    if (nv_prog_strobe === 1'b1)
      n_strobe <= n_strobe + 1;

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_errors++;
      end_sim();
    end
    else
    begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // the map updates on the edge that completes a write, so look just after it
  task automatic mapchk(input logic [1:0] e);
    #1;
    chk({30'h0, memory_map_config}, {30'h0, e});
  endtask

  // fetch and programming address presented together, result one cycle later
  task automatic steer(input logic [15:0] a, input logic ib, input logic ef,
                       input logic ei);
    @(posedge pclk);
    fetch_valid <= 1'b1;
    fetch_pc <= a;
    iap_valid <= 1'b1;
    iap_addr <= a;
    iap_blk1 <= ib;
    @(posedge pclk);
    fetch_valid <= 1'b0;
    iap_valid <= 1'b0;
    #1;
    chk({14'h0, fetch_sel}, {14'h0, 1'b1, ef, a});
    chk({14'h0, iap_sel}, {14'h0, 1'b1, ei, a});
  endtask

  task automatic warm(input pmbs_pkg::pmbs_rst_kind_t k);
    @(posedge pclk);
    warm_rst_req <= 1'b1;
    warm_rst_kind <= k;
    @(posedge pclk);
    warm_rst_req <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic cold;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    #1;
  endtask

  // poll the busy flag; busy may lag the command by a few cycles
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (4) @(posedge pclk);
    do
    begin
      apb(1'b0, pmbs_pkg::OFF_STAT, 32'h0000_0000);
      n++;
    end
    while (rd[4] !== 1'b0 && n < 200);
    if (n >= 200)
    begin
      n_errors++;
      end_sim();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, warm_rst_req, fetch_valid, iap_valid, iap_blk1} = 7'h00;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    warm_rst_kind = pmbs_pkg::RK_COLD;
    fetch_pc = 16'h0000;
    iap_addr = 16'h0000;
    host_prog_pin = 1'b0;
    {n_errors, num_checks, n_strobe} = '0;
    cold();
    mapchk(2'h0);
    steer(16'h0100, 1'b0, 1'b1, 1'b0);
    steer(16'h1FFF, 1'b0, 1'b1, 1'b0);
    steer(16'h2000, 1'b1, 1'b0, 1'b0);
    steer(16'hFFFF, 1'b1, 1'b0, 1'b0);
    apb(1'b1, pmbs_pkg::OFF_MAP, 32'h0000_0003);
    mapchk(2'h1);
    apb(1'b0, pmbs_pkg::OFF_MAP, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    steer(16'h0100, 1'b1, 1'b0, 1'b1);
    apb(1'b0, pmbs_pkg::OFF_STAT, 32'h0000_0000);
    chk({31'h0, rd[0]}, 32'h0000_0001);
    chk({31'h0, err}, 32'h0000_0000);
    apb(1'b0, 32'h0000_0010, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    warm(pmbs_pkg::RK_WARM);
    mapchk(2'h0);
    warm(pmbs_pkg::RK_SW);
    mapchk(2'h2);
    warm(pmbs_pkg::RK_WARM);
    mapchk(2'h2);
    apb(1'b1, pmbs_pkg::OFF_MAP, 32'h0000_0001);
    mapchk(2'h3);
    steer(16'h0000, 1'b0, 1'b0, 1'b0);
    apb(1'b1, pmbs_pkg::OFF_IAP, 32'h0000_005A);
    wait_idle();
    chk(n_strobe, 32'h0000_0000);
    apb(1'b1, pmbs_pkg::OFF_IAP, pmbs_pkg::IAP_KEY_PROG_SC);
    wait_idle();
    chk(n_strobe, 32'h0000_0001);
    chk({28'h0, rd[3:0]}, 32'h0000_0006);
    mapchk(2'h3);
    apb(1'b1, pmbs_pkg::OFF_IAP, pmbs_pkg::IAP_KEY_PROG_SC);
    wait_idle();
    chk(n_strobe, 32'h0000_0001);
    chk({31'h0, rd[5]}, 32'h0000_0001);
    warm(pmbs_pkg::RK_WARM);
    mapchk(2'h3);
    warm(pmbs_pkg::RK_SW);
    mapchk(2'h3);
    warm(pmbs_pkg::RK_COLD);
    mapchk(2'h1);
    cold();
    mapchk(2'h1);
    @(posedge pclk);
    host_prog_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    host_prog_pin <= 1'b0;
    wait_idle();
    chk(n_strobe, 32'h0000_0001);
    chk({31'h0, rd[5]}, 32'h0000_0001);
    apb(1'b1, pmbs_pkg::OFF_MAP, 32'h0000_0003);
    wait_idle();
    chk({26'h0, rd[5:0]}, 32'h0000_0002);
    apb(1'b1, pmbs_pkg::OFF_MAP, 32'h0000_0000);
    mapchk(2'h0);
    steer(16'h0100, 1'b1, 1'b1, 1'b1);
    end_sim();
  end

  initial
  begin
    #900000;
    n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
